/* rtl/awg_consts.svh */
// constants for the four-channel waveform command engine
`ifndef AWG_CONSTS_SVH
`define AWG_CONSTS_SVH
// register offsets of the command port (word index)
`define ADDR_COMMAND_WORD 8'h00
`define ADDR_COMMAND_RESPONSE 8'h01
`define ADDR_CHANNEL_SELECTOR 8'h02
`define ADDR_COMMAND_ARGUMENT 8'h03
`define ADDR_SOURCE_START_HIGH 8'h04
`define ADDR_SOURCE_START_LOW 8'h05
`define ADDR_SOURCE_END_HIGH 8'h06
`define ADDR_SOURCE_END_LOW 8'h07
`define ADDR_DEST_START_HIGH 8'h08
`define ADDR_DEST_START_LOW 8'h09
`define ADDR_REPEAT_BASE 8'h10
`define ADDR_RATE_HIGH_BASE 8'h14
`define ADDR_RATE_LOW_BASE 8'h18
`define ADDR_STATUS_BASE 8'h1C
`define ADDR_DAC_BASE 8'h20
`define ADDR_RATE_ACTIVE_BASE 8'h24
// command codes
`define CMD_NULL 16'h0000
`define CMD_INIT 16'h0005
`define CMD_LOAD_TABLE 16'h0006
`define CMD_TRIGGER 16'h0007
`define CMD_SAMPLE_RATE 16'h0009
`define CMD_SQUARE 16'h000A
`define CMD_PING 16'h000D
`define CMD_BIT 16'h000E
`define CMD_REPEAT 16'h0012
`define CMD_POINTERS 16'h0013
// responses
`define RSP_OK 16'h0001
`define RSP_REJECT 16'h0002
`define RSP_PING 16'hBEEF
// sizes and limits
`define MAX_SINGLE_LOAD 17'h0_E000
`define MAX_TOTAL_WORDS 18'h1_0000
`define SHARED_FIRST_WORD 17'h0_4000
`define BIT_RESULT_BASE 17'h0_4000
`define BIT_RESULT_WORDS 17'h0_0012
`define REPEAT_CONTINUOUS 9'h1FF
`define SQUARE_HALF 17'h0_0020
`define SQUARE_HIGH 16'h7FFF
`define SQUARE_LOW 16'h8000
`define RATE_RESET 32'h0000_0010
`endif

/* rtl/awg_pkg.sv */
// types for the four-channel waveform command engine
package awg_pkg;
  // engine states, codes as seen in the status register
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_ARMED = 3'b011,
    ST_DONE = 3'b100,
    ST_WAVE = 3'b111
  } eng_state_t;
  // command sequencer states
  typedef enum logic [1:0] {
    SQ_WAIT = 2'b00,
    SQ_COPY = 2'b01,
    SQ_BIT = 2'b10,
    SQ_FINISH = 2'b11
  } seq_state_t;
  // shared ram request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [16:0] addr;
    logic [15:0] wdata;
  } shr_req_t;
  // adc request
  typedef struct packed {
    logic start;
    logic [2:0] port;
    logic [1:0] atten;
  } adc_req_t;
endpackage

/* rtl/awg_channel_command_engine.sv */
// mailbox command engine with four channel playback engines
//
// Summary of operation
// - init command 0x0005 zeroes channel engine state
// - halt stops output, dac keeps last value
// - after halt idle; trigger only when armed
// - pointer command 0x13 moves idle to load
// - nonzero repeat count moves load to armed
// - waveform memory survives halt, no reload needed
// - repeat one during wave: finish cycle, done
// - nonzero repeat from done rearms the engine
// - load command copies shared words uncorrected
// - one load 1 to 57344 words, total 65536
// - destination pointer 17 bits, high bit separate
// - destination independent of source start pointer
// - software trigger starts armed channel only
// - rate command reloads only selected channel rate
// - square command presets channel, plays square wave
// - ping writes 0xBEEF into command response
// - built-in test stores averages from offset 0x4000
// - results are 20-bit left-justified high/low words
// - device clears command word to zero when done
// - repeat count 9 bits, 511 means continuous
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ns
`include "awg_consts.svh"
module awg_channel_command_engine
  import awg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // shared host ram, one cycle read latency
  output shr_req_t shr_req_o,
  input wire logic [15:0] shr_rdata_i,
  // adc for the built-in test
  output adc_req_t adc_req_o,
  input wire logic adc_done_i,
  input wire logic [19:0] adc_data_i,
  // per-channel sample clock ticks, from outside this domain
  input wire logic [3:0] sample_tick_i,
  // dac sample outputs
  output logic [63:0] dac_data_o
);
  // ****************************************************************
  // mailbox registers
  // ****************************************************************
  logic [15:0] command_word_q; // nonzero while a command runs
  logic [15:0] command_response_q; // answer code
  logic [1:0] channel_selector_q; // channel of the command
  logic [15:0] command_argument_q; // test argument
  logic [15:0] src_start_hi_q, src_start_lo_q; // shared ram start
  logic [15:0] src_end_hi_q, src_end_lo_q; // shared ram end
  logic dest_start_hi_q; // only one bit is kept
  logic [15:0] dest_start_lo_q;
  logic [8:0] repeat_cycle_count_q [4]; // host-written counts
  logic [15:0] rate_hi_q [4], rate_lo_q [4]; // staged rates
  logic [31:0] rate_active_q [4]; // rate the channel clock uses
  // channel state
  eng_state_t eng_q [4];
  logic [16:0] ptr_start_q [4], ptr_end_q [4], rd_ptr_q [4];
  logic [8:0] cycles_left_q [4]; // playback cycles to go
  logic [15:0] dac_q [4];
  logic [15:0] wave_mem [4][65536]; // channel waveform memories
  // sequencer
  seq_state_t seq_q;
  logic [16:0] cnt_q; // words left to copy
  logic [16:0] dst_q; // next destination word
  logic [16:0] src_q; // next source word
  logic rd_pend_q; // shared read answer due this cycle
  logic [16:0] bit_idx_q; // test result word index
  logic [31:0] bit_word_q; // left-justified sample
  logic adc_busy_q;
  logic sq_fill_q; // copy is the square preset fill
  // sample tick synchronisers
  logic [3:0] tick_s1_q, tick_s2_q, tick_s3_q;
  logic [3:0] tick_rise;
  // decoded command strobes
  logic cmd_start;
  logic [16:0] src_start, src_end, src_len;
  logic [15:0] rd_data_d;
  assign src_start = {src_start_hi_q[0], src_start_lo_q};
  assign src_end = {src_end_hi_q[0], src_end_lo_q};
  assign src_len = src_end - src_start;
  assign cmd_start = (seq_q == SQ_WAIT) && (command_word_q != `CMD_NULL);
  // ****************************************************************
  // host writes into mailbox registers
  // ****************************************************************
  // the command word is also cleared by the sequencer; a host write wins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      command_word_q <= `CMD_NULL;
    end else if (reg_wr_i && reg_addr_i == `ADDR_COMMAND_WORD) begin
      command_word_q <= reg_wdata_i;
    end else if (seq_q == SQ_FINISH) begin
      command_word_q <= `CMD_NULL;
    end
  end
  // plain parameter registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      channel_selector_q <= 2'h0;
      command_argument_q <= 16'h0000;
      src_start_hi_q <= 16'h0000;
      src_start_lo_q <= 16'h0000;
      src_end_hi_q <= 16'h0000;
      src_end_lo_q <= 16'h0000;
      dest_start_hi_q <= 1'b0;
      dest_start_lo_q <= 16'h0000;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `ADDR_CHANNEL_SELECTOR) begin
        channel_selector_q <= reg_wdata_i[1:0];
      end else if (reg_addr_i == `ADDR_COMMAND_ARGUMENT) begin
        command_argument_q <= reg_wdata_i;
      end else if (reg_addr_i == `ADDR_SOURCE_START_HIGH) begin
        src_start_hi_q <= reg_wdata_i;
      end else if (reg_addr_i == `ADDR_SOURCE_START_LOW) begin
        src_start_lo_q <= reg_wdata_i;
      end else if (reg_addr_i == `ADDR_SOURCE_END_HIGH) begin
        src_end_hi_q <= reg_wdata_i;
      end else if (reg_addr_i == `ADDR_SOURCE_END_LOW) begin
        src_end_lo_q <= reg_wdata_i;
      end else if (reg_addr_i == `ADDR_DEST_START_HIGH) begin
        dest_start_hi_q <= reg_wdata_i[0];
      end else if (reg_addr_i == `ADDR_DEST_START_LOW) begin
        dest_start_lo_q <= reg_wdata_i;
      end
    end
  end
  // ****************************************************************
  // per-channel logic
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_ch
      logic sel;
      logic run_cmd;
      assign sel = (channel_selector_q == 2'(g));
      assign run_cmd = cmd_start && sel;
      // tick synchroniser: second and third stage feed the edge detector
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          tick_s1_q[g] <= 1'b0;
          tick_s2_q[g] <= 1'b0;
          tick_s3_q[g] <= 1'b0;
        end else begin
          tick_s1_q[g] <= sample_tick_i[g];
          tick_s2_q[g] <= tick_s1_q[g];
          tick_s3_q[g] <= tick_s2_q[g];
        end
      end
      assign tick_rise[g] = tick_s2_q[g] & ~tick_s3_q[g];
      // staged repeat count and rate registers
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          repeat_cycle_count_q[g] <= 9'h000;
          rate_hi_q[g] <= 16'h0000;
          rate_lo_q[g] <= 16'h0000;
        end else if (reg_wr_i) begin
          if (reg_addr_i == `ADDR_REPEAT_BASE + 8'(g)) begin
            repeat_cycle_count_q[g] <= reg_wdata_i[8:0];
          end else if (reg_addr_i == `ADDR_RATE_HIGH_BASE + 8'(g)) begin
            rate_hi_q[g] <= reg_wdata_i;
          end else if (reg_addr_i == `ADDR_RATE_LOW_BASE + 8'(g)) begin
            rate_lo_q[g] <= reg_wdata_i;
          end
        end
      end
      // active sample rate reloads only for the named channel
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          rate_active_q[g] <= `RATE_RESET;
        end else if (run_cmd && command_word_q == `CMD_SAMPLE_RATE) begin
          rate_active_q[g] <= {rate_hi_q[g], rate_lo_q[g]};
        end
      end
      // engine state machine; memory untouched by halt or init
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          eng_q[g] <= ST_IDLE;
          cycles_left_q[g] <= 9'h000;
          ptr_start_q[g] <= 17'h0_0000;
          ptr_end_q[g] <= 17'h0_0000;
          rd_ptr_q[g] <= 17'h0_0000;
        end else if (run_cmd && command_word_q == `CMD_INIT) begin
          eng_q[g] <= ST_IDLE;
        end else if (run_cmd && command_word_q == `CMD_POINTERS) begin
          ptr_start_q[g] <= {dest_start_hi_q, dest_start_lo_q};
          ptr_end_q[g] <= src_end - src_start + {dest_start_hi_q, dest_start_lo_q} - 17'h0_0001;
          if (eng_q[g] == ST_IDLE) begin
            eng_q[g] <= ST_LOAD;
          end
        end else if (run_cmd && command_word_q == `CMD_REPEAT) begin
          cycles_left_q[g] <= repeat_cycle_count_q[g];
          if ((eng_q[g] == ST_LOAD || eng_q[g] == ST_DONE)
              && repeat_cycle_count_q[g] != 9'h000) begin
            eng_q[g] <= ST_ARMED;
          end
        end else if (run_cmd && command_word_q == `CMD_SQUARE) begin
          ptr_start_q[g] <= 17'h0_0000;
          ptr_end_q[g] <= `SQUARE_HALF + `SQUARE_HALF - 17'h0_0001;
          rd_ptr_q[g] <= 17'h0_0000;
          cycles_left_q[g] <= `REPEAT_CONTINUOUS;
          eng_q[g] <= ST_WAVE;
        end else if (run_cmd && command_word_q == `CMD_TRIGGER) begin
          if (eng_q[g] == ST_ARMED) begin
            eng_q[g] <= ST_WAVE;
            rd_ptr_q[g] <= ptr_start_q[g];
          end
        end else if (eng_q[g] == ST_WAVE && tick_rise[g]) begin
          if (rd_ptr_q[g] != ptr_end_q[g]) begin
            rd_ptr_q[g] <= rd_ptr_q[g] + 17'h0_0001;
          end else if (cycles_left_q[g] == `REPEAT_CONTINUOUS) begin
            rd_ptr_q[g] <= ptr_start_q[g];
          end else if (cycles_left_q[g] <= 9'h001
                       || repeat_cycle_count_q[g] == 9'h001) begin
            eng_q[g] <= ST_DONE;
          end else begin
            cycles_left_q[g] <= cycles_left_q[g] - 9'h001;
            rd_ptr_q[g] <= ptr_start_q[g];
          end
        end
      end
      // dac holds the last value whenever the engine leaves wave
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          dac_q[g] <= 16'h0000;
        end else if (eng_q[g] == ST_WAVE && tick_rise[g]) begin
          dac_q[g] <= wave_mem[g][rd_ptr_q[g][15:0]];
        end
      end
      assign dac_data_o[16*g +: 16] = dac_q[g];
      // waveform memory write port, fed by the sequencer
      always_ff @(posedge clk_i) begin
        if (rd_pend_q && sel) begin
          wave_mem[g][dst_q[15:0]] <= sq_fill_q
            ? (dst_q < `SQUARE_HALF ? `SQUARE_HIGH : `SQUARE_LOW)
            : shr_rdata_i;
        end
      end
    end
  endgenerate
  // ****************************************************************
  // command sequencer: table copy, built-in test, completion
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      seq_q <= SQ_WAIT;
      cnt_q <= 17'h0_0000;
      dst_q <= 17'h0_0000;
      src_q <= 17'h0_0000;
      rd_pend_q <= 1'b0;
      bit_idx_q <= 17'h0_0000;
      adc_busy_q <= 1'b0;
      sq_fill_q <= 1'b0;
      bit_word_q <= 32'h0000_0000;
      command_response_q <= 16'h0000;
    end else begin
      rd_pend_q <= 1'b0;
      case (seq_q)
        SQ_WAIT: begin
          if (cmd_start) begin
            command_response_q <= `RSP_OK;
            seq_q <= SQ_FINISH;
            if (command_word_q == `CMD_PING) begin
              command_response_q <= `RSP_PING;
            end else if (command_word_q == `CMD_LOAD_TABLE) begin
              if (src_end <= src_start || src_start < `SHARED_FIRST_WORD
                  || src_len > `MAX_SINGLE_LOAD) begin
                command_response_q <= `RSP_REJECT;
              end else begin
                seq_q <= SQ_COPY;
                cnt_q <= src_len;
                src_q <= src_start;
                dst_q <= {dest_start_hi_q, dest_start_lo_q};
                sq_fill_q <= 1'b0;
              end
            end else if (command_word_q == `CMD_SQUARE) begin
              seq_q <= SQ_COPY;
              cnt_q <= `SQUARE_HALF + `SQUARE_HALF;
              dst_q <= 17'h0_0000;
              sq_fill_q <= 1'b1;
            end else if (command_word_q == `CMD_BIT) begin
              if (command_argument_q == 16'h0000) begin
                seq_q <= SQ_BIT;
                bit_idx_q <= 17'h0_0000;
                adc_busy_q <= 1'b0;
              end
            end
          end
        end
        SQ_COPY: begin
          // one shared read per cycle, written when its data returns
          if (rd_pend_q) begin
            dst_q <= dst_q + 17'h0_0001;
          end
          if (cnt_q != 17'h0_0000) begin
            cnt_q <= cnt_q - 17'h0_0001;
            src_q <= src_q + 17'h0_0001;
            rd_pend_q <= 1'b1;
          end else if (!rd_pend_q) begin
            seq_q <= SQ_FINISH;
          end
        end
        SQ_BIT: begin
          // each reference gives a high word then a low word
          if (!adc_busy_q && !bit_idx_q[0]) begin
            adc_busy_q <= 1'b1;
          end else if (adc_busy_q && adc_done_i) begin
            adc_busy_q <= 1'b0;
            bit_word_q <= {adc_data_i, 12'h000};
            bit_idx_q <= bit_idx_q + 17'h0_0001;
          end else if (bit_idx_q[0]) begin
            bit_idx_q <= bit_idx_q + 17'h0_0001;
            if (bit_idx_q + 17'h0_0001 == `BIT_RESULT_WORDS) begin
              seq_q <= SQ_FINISH;
            end
          end
        end
        SQ_FINISH: begin
          seq_q <= SQ_WAIT;
        end
        default: begin
          seq_q <= SQ_WAIT;
        end
      endcase
    end
  end
  // shared ram access: copy reads, test result writes
  always_comb begin
    shr_req_o = '0;
    if (seq_q == SQ_COPY && cnt_q != 17'h0_0000 && !sq_fill_q) begin
      shr_req_o.rd = 1'b1;
      shr_req_o.addr = src_q;
    end else if (seq_q == SQ_BIT && adc_busy_q && adc_done_i) begin
      shr_req_o.wr = 1'b1;
      shr_req_o.addr = `BIT_RESULT_BASE + bit_idx_q;
      shr_req_o.wdata = adc_data_i[19:4];
    end else if (seq_q == SQ_BIT && bit_idx_q[0]) begin
      shr_req_o.wr = 1'b1;
      shr_req_o.addr = `BIT_RESULT_BASE + bit_idx_q;
      shr_req_o.wdata = bit_word_q[15:0];
    end
  end
  // adc start pulse; reference port and attenuator follow the index
  always_comb begin
    adc_req_o.start = (seq_q == SQ_BIT) && !adc_busy_q && !bit_idx_q[0];
    adc_req_o.port = bit_idx_q[4:2] == 3'h0 ? 3'h4 : 3'h7;
    adc_req_o.atten = bit_idx_q[4:3];
  end
  // ****************************************************************
  // register read port, data one cycle after the strobe
  // ****************************************************************
  always_comb begin
    rd_data_d = 16'h0000;
    if (reg_addr_i == `ADDR_COMMAND_WORD) begin
      rd_data_d = command_word_q;
    end else if (reg_addr_i == `ADDR_COMMAND_RESPONSE) begin
      rd_data_d = command_response_q;
    end else if (reg_addr_i == `ADDR_CHANNEL_SELECTOR) begin
      rd_data_d = {14'h0000, channel_selector_q};
    end else if (reg_addr_i == `ADDR_COMMAND_ARGUMENT) begin
      rd_data_d = command_argument_q;
    end else if (reg_addr_i[7:2] == 6'(`ADDR_REPEAT_BASE >> 2)) begin
      rd_data_d = {7'h00, repeat_cycle_count_q[reg_addr_i[1:0]]};
    end else if (reg_addr_i[7:2] == 6'(`ADDR_STATUS_BASE >> 2)) begin
      rd_data_d = {13'h0000, eng_q[reg_addr_i[1:0]]};
    end else if (reg_addr_i[7:2] == 6'(`ADDR_DAC_BASE >> 2)) begin
      rd_data_d = dac_q[reg_addr_i[1:0]];
    end else if (reg_addr_i[7:2] == 6'(`ADDR_RATE_ACTIVE_BASE >> 2)) begin
      rd_data_d = rate_active_q[reg_addr_i[1:0]][15:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_data_d;
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_init_idle;
    @(posedge clk_i) disable iff (!rst_n_i)
      cmd_start && command_word_q == `CMD_INIT |=> eng_q[channel_selector_q] == ST_IDLE;
  endproperty
  a_init_idle: assert property (p_init_idle) else $error("init left engine busy");
  property p_ping;
    @(posedge clk_i) disable iff (!rst_n_i)
      cmd_start && command_word_q == `CMD_PING |=> command_response_q == `RSP_PING;
  endproperty
  a_ping: assert property (p_ping) else $error("ping answer wrong");
  property p_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
      seq_q == SQ_FINISH && !reg_wr_i |=> command_word_q == `CMD_NULL;
  endproperty
  a_clear: assert property (p_clear) else $error("command word not cleared");
  property p_trig_armed;
    @(posedge clk_i) disable iff (!rst_n_i)
      cmd_start && command_word_q == `CMD_TRIGGER && channel_selector_q == 2'h0
      && eng_q[0] != ST_ARMED |=> eng_q[0] == $past(eng_q[0]);
  endproperty
  a_trig_armed: assert property (p_trig_armed) else $error("trigger acted unarmed");
  property p_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      eng_q[0] != ST_WAVE |=> dac_q[0] == $past(dac_q[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("dac moved when stopped");
  property p_ptr_load;
    @(posedge clk_i) disable iff (!rst_n_i)
      cmd_start && command_word_q == `CMD_POINTERS && channel_selector_q == 2'h0
      && eng_q[0] == ST_IDLE |=> eng_q[0] == ST_LOAD;
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("no load state");
  property p_arm;
    @(posedge clk_i) disable iff (!rst_n_i)
      cmd_start && command_word_q == `CMD_REPEAT && channel_selector_q == 2'h0
      && eng_q[0] == ST_LOAD && repeat_cycle_count_q[0] != 9'h000 |=> eng_q[0] == ST_ARMED;
  endproperty
  a_arm: assert property (p_arm) else $error("not armed");
  property p_rate;
    @(posedge clk_i) disable iff (!rst_n_i)
      cmd_start && command_word_q == `CMD_SAMPLE_RATE && channel_selector_q != 2'h0
      |=> $stable(rate_active_q[0]);
  endproperty
  a_rate: assert property (p_rate) else $error("wrong channel rate");
  c_ping: cover property (@(posedge clk_i) cmd_start && command_word_q == `CMD_PING);
  c_wave: cover property (@(posedge clk_i) eng_q[0] == ST_WAVE);
  c_done: cover property (@(posedge clk_i) eng_q[0] == ST_DONE);
endmodule

/* bench/host_side_model.sv */
// shared host ram and adc stand-in on the far side of the command engine
`timescale 1ns/1ns
module host_side_model
  import awg_pkg::*;
(
  // clock
  input wire logic clk_i,
  // shared ram port
  input wire shr_req_t shr_req_i,
  output logic [15:0] shr_rdata_o,
  // adc port
  input wire adc_req_t adc_req_i,
  output logic adc_done_o,
  output logic [19:0] adc_data_o
);
  logic [15:0] mem [logic [16:0]]; // words the engine wrote back
  logic [2:0] wait_q; // conversion delay count
  initial begin
    shr_rdata_o = 16'h0000;
    adc_done_o = 1'b0;
    adc_data_o = 20'h0_0000;
    wait_q = 3'h0;
  end
  // ram answers one cycle after a read; the bus wanders when idle, so stale data shows
  always @(posedge clk_i) begin
    if (shr_req_i.wr) mem[shr_req_i.addr] = shr_req_i.wdata;
    if (shr_req_i.rd) shr_rdata_o <= shr_req_i.addr[15:0] ^ 16'h5A3C;
    else shr_rdata_o <= ~shr_rdata_o;
  end
  // adc converts for a few cycles after a start pulse, then pulses done with a fixed sample
  always @(posedge clk_i) begin
    adc_done_o <= 1'b0;
    adc_data_o <= ~adc_data_o;
    if (adc_req_i.start) wait_q <= 3'h1;
    else if (wait_q != 3'h0) wait_q <= wait_q + 3'h1;
    if (wait_q == 3'h4) begin
      adc_done_o <= 1'b1;
      adc_data_o <= 20'hA_BCDE;
      wait_q <= 3'h0;
    end
  end
endmodule

/* bench/testbench.sv */
// self-checking bench for the channel command engine
`timescale 1ns/1ns
`include "awg_consts.svh"
module testbench;
  import awg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] reg_rdata_o;
  shr_req_t shr_req_o;
  logic [15:0] shr_rdata_i;
  adc_req_t adc_req_o;
  logic adc_done_i;
  logic [19:0] adc_data_i;
  logic [3:0] sample_tick_i = 4'h0; // all channels share one slow tick
  logic [63:0] dac_data_o;
  logic [3:0] div_q = 4'h0; // tick divider, one tick per 8 clocks
  logic [15:0] rd_v; // last register read
  int errors = 0;
  int comparisons = 0;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    div_q <= div_q + 4'h1;
    sample_tick_i <= {4{div_q[2]}};
  end
  awg_channel_command_engine dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .shr_req_o(shr_req_o), .shr_rdata_i(shr_rdata_i), .adc_req_o(adc_req_o),
    .adc_done_i(adc_done_i), .adc_data_i(adc_data_i), .sample_tick_i(sample_tick_i),
    .dac_data_o(dac_data_o));
  host_side_model far_side (.clk_i(clk_i), .shr_req_i(shr_req_o), .shr_rdata_o(shr_rdata_i),
    .adc_req_i(adc_req_o), .adc_done_o(adc_done_i), .adc_data_o(adc_data_i));
  // ****************************************
  // bus tasks and checks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 rd_v = reg_rdata_o;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // issue a command, poll until the word clears, then fetch the response
  task automatic cmd(input logic [15:0] c);
    int n;
    n = 0;
    wr(`ADDR_COMMAND_WORD, c);
    rd(`ADDR_COMMAND_WORD);
    while (rd_v !== 16'h0000 && n < 3000) begin
      rd(`ADDR_COMMAND_WORD);
      n++;
    end
    chk("command word", 16'h0000, rd_v);
    rd(`ADDR_COMMAND_RESPONSE);
  endtask
  task automatic st(input logic [7:0] ch, input logic [2:0] e);
    rd(`ADDR_STATUS_BASE + ch);
    chk("engine state", {13'h0000, e}, {13'h0000, rd_v[2:0]});
  endtask
  // pointers, repeat count, trigger: walk channel 0 from idle to wave
  task automatic arm;
    cmd(`CMD_POINTERS);
    st(8'h00, ST_LOAD);
    cmd(`CMD_REPEAT);
    st(8'h00, ST_ARMED);
    cmd(`CMD_TRIGGER);
    st(8'h00, ST_WAVE);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cmd(`CMD_PING);
    chk("ping response", `RSP_PING, rd_v);
    $display("test ping done");
    cmd(`CMD_INIT);
    st(8'h00, ST_IDLE);
    cmd(`CMD_TRIGGER);
    st(8'h00, ST_IDLE);
    // source start one word below the shared window must be refused
    wr(`ADDR_SOURCE_START_LOW, 16'h3FFF);
    wr(`ADDR_SOURCE_END_LOW, 16'h4010);
    cmd(`CMD_LOAD_TABLE);
    chk("load refused", `RSP_REJECT, rd_v);
    // a table longer than one load allows must be refused too
    wr(`ADDR_SOURCE_START_LOW, 16'h4000);
    wr(`ADDR_SOURCE_END_HIGH, 16'h0001);
    cmd(`CMD_LOAD_TABLE);
    chk("long load refused", `RSP_REJECT, rd_v);
    // 16 words to the start of channel memory; destination bit 16 is set but the memory index drops it
    wr(`ADDR_SOURCE_END_HIGH, 16'h0000);
    wr(`ADDR_DEST_START_HIGH, 16'h0001);
    cmd(`CMD_LOAD_TABLE);
    chk("load response", `RSP_OK, rd_v);
    wr(`ADDR_REPEAT_BASE, 16'h0001);
    arm();
    repeat (300) @(posedge clk_i);
    st(8'h00, ST_DONE);
    chk("held sample", 16'h400F ^ 16'h5A3C, dac_data_o[15:0]);
    $display("test load and single cycle done");
    wr(`ADDR_REPEAT_BASE, 16'h01FF);
    cmd(`CMD_REPEAT);
    st(8'h00, ST_ARMED);
    cmd(`CMD_TRIGGER);
    repeat (300) @(posedge clk_i);
    st(8'h00, ST_WAVE);
    wr(`ADDR_REPEAT_BASE, 16'h0001);
    cmd(`CMD_REPEAT);
    repeat (300) @(posedge clk_i);
    st(8'h00, ST_DONE);
    wr(`ADDR_REPEAT_BASE, 16'h01FF);
    cmd(`CMD_INIT);
    arm();
    cmd(`CMD_INIT);
    st(8'h00, ST_IDLE);
    arm();
    $display("test halt and rearm done");
    wr(`ADDR_CHANNEL_SELECTOR, 16'h0001);
    wr(`ADDR_RATE_LOW_BASE + 8'h01, 16'h1234);
    cmd(`CMD_SAMPLE_RATE);
    rd(`ADDR_RATE_ACTIVE_BASE + 8'h01);
    chk("rate chan 1", 16'h1234, rd_v);
    rd(`ADDR_RATE_ACTIVE_BASE);
    chk("rate chan 0", 16'h0010, rd_v);
    wr(`ADDR_CHANNEL_SELECTOR, 16'h0002);
    cmd(`CMD_SQUARE);
    st(8'h02, ST_WAVE);
    $display("test rate and square done");
    wr(`ADDR_COMMAND_ARGUMENT, 16'h0000);
    cmd(`CMD_BIT);
    chk("result high", 16'hABCD, far_side.mem[17'h0_4000]);
    chk("result low", 16'hE000, far_side.mem[17'h0_4001]);
    $display("test built-in test done");
    print_verdict();
  end
  // cut a hang short well past the expected run length
  initial begin
    #2000000;
    errors++;
    print_verdict();
  end
endmodule
